//--- src/serdes_ctrl.sv
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module serdes_ctrl
    import serdes_ctrl_pkg::*;
#(
    parameter int         MAX_W        = 20,
    parameter int         PREEMPH_W    = 5,
    parameter logic [4:0] PREEMPH_INIT = 5'h00,
    parameter logic [1:0] RX_PLL_BW    = BW_MEDIUM
) (
    input  wire logic                 clk_in,
    input  wire logic                 reset_in,
    input  wire logic [ADDR_W-1:0]    s_axi_awaddr_in,
    input  wire logic                 s_axi_awvalid_in,
    output logic                      s_axi_awready_out,
    input  wire logic [31:0]          s_axi_wdata_in,
    input  wire logic [3:0]           s_axi_wstrb_in,
    input  wire logic                 s_axi_wvalid_in,
    output logic                      s_axi_wready_out,
    output logic [1:0]                s_axi_bresp_out,
    output logic                      s_axi_bvalid_out,
    input  wire logic                 s_axi_bready_in,
    input  wire logic [ADDR_W-1:0]    s_axi_araddr_in,
    input  wire logic                 s_axi_arvalid_in,
    output logic                      s_axi_arready_out,
    output logic [31:0]               s_axi_rdata_out,
    output logic [1:0]                s_axi_rresp_out,
    output logic                      s_axi_rvalid_out,
    input  wire logic                 s_axi_rready_in,
    input  wire logic [MAX_W-1:0]     tx_word_in,
    input  wire logic                 tx_word_valid_in,
    output logic                      tx_word_ready_out,
    output logic                      tx_serial_out,
    output logic                      tx_oe_out,
    output logic                      tx_elec_idle_out,
    input  wire logic                 force_elec_idle_in,
    output logic                      rxdet_pulse_out,
    input  wire logic                 reflection_in,
    input  wire logic                 lock_to_data_in,
    input  wire logic                 lock_to_ref_in,
    input  wire logic                 ppm_ok_in,
    input  wire logic                 ref_locked_in,
    input  wire logic                 data_locked_in,
    input  wire logic                 eq_settled_in,
    output logic                      lock_to_data_sel_out,
    output logic                      rx_pll_locked_out,
    output logic                      freq_locked_out,
    output logic                      pfd_lock_out,
    output logic                      pd_lock_out,
    output logic                      rx_pll_pd_out,
    output logic [4:0]                mult_factor_out,
    output logic [1:0]                rx_pll_bw_out,
    output logic                      eq_adapt_pd_out,
    output logic [PREEMPH_W-1:0]      preemph_out,
    output logic                      irq_out
);

    typedef struct packed {
        logic                 aw_got;
        logic                 w_got;
        logic [ADDR_W-1:0]    awaddr;
        logic [31:0]          wdata;
        logic [3:0]           wstrb;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 rvalid;
        logic [31:0]          rdata;
        logic [1:0]           rresp;
        logic [31:0]          ctrl;
        logic [IRQ_W-1:0]     irq_stat;
        logic [IRQ_W-1:0]     irq_mask;
        logic [2:0]           mult_sel;
        logic [PREEMPH_W-1:0] preemph;
        cru_type              cru;
        det_type              det;
        logic [7:0]           det_cnt;
        logic                 det_pulse;
        logic                 rx_present;
        logic                 tx_idle;
        logic                 pll_locked;
        logic                 pfd_lock;
        logic                 pd_lock;
        logic                 eq_pd;
    } state_type;

    state_type        st_reg;
    state_type        st_next;
    logic             wr_fire;
    logic             det_go;
    logic             force_data;
    logic             force_ref;
    logic             chan_en;
    logic [IRQ_W-1:0] irq_ev;
    logic [IRQ_W-1:0] irq_clr;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                old[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        merge = old;
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = (a[ADDR_W-1:2] <= OFS_PREEMPH[ADDR_W-1:2]);
    endfunction

    // ==========================================================
    // Bus handshakes
    assign s_axi_awready_out = !st_reg.aw_got && !st_reg.bvalid;
    assign s_axi_wready_out  = !st_reg.w_got && !st_reg.bvalid;
    assign s_axi_arready_out = !st_reg.rvalid;
    assign s_axi_bvalid_out  = st_reg.bvalid;
    assign s_axi_bresp_out   = st_reg.bresp;
    assign s_axi_rvalid_out  = st_reg.rvalid;
    assign s_axi_rdata_out   = st_reg.rdata;
    assign s_axi_rresp_out   = st_reg.rresp;
    assign wr_fire           = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;

    // ==========================================================
    // Mode selection and outputs
    // Override inputs are tied low when unused, leaving automatic mode
    assign chan_en    = st_reg.ctrl[CTRL_CHAN_EN];
    assign force_data = lock_to_data_in || st_reg.ctrl[CTRL_FORCE_DATA]; // R10
    assign force_ref  = lock_to_ref_in || st_reg.ctrl[CTRL_FORCE_REF]; // R10
    assign det_go     = wr_fire && st_reg.awaddr[ADDR_W-1:2] == OFS_CTRL[ADDR_W-1:2]
                        && st_reg.wstrb[0] && st_reg.wdata[CTRL_DET_START]
                        && st_reg.tx_idle && st_reg.det == DET_IDLE; // R03
    assign irq_clr    = (wr_fire && st_reg.awaddr[ADDR_W-1:2] == OFS_IRQ_STAT[ADDR_W-1:2]
                        && st_reg.wstrb[0]) ? st_reg.wdata[IRQ_W-1:0] : '0;

    assign lock_to_data_sel_out = st_reg.cru == CRU_DATA;
    assign freq_locked_out      = st_reg.cru == CRU_DATA; // R07
    assign rx_pll_locked_out    = st_reg.pll_locked;
    assign pfd_lock_out         = st_reg.pfd_lock;
    assign pd_lock_out          = st_reg.pd_lock;
    assign rx_pll_pd_out        = !chan_en; // R05
    assign mult_factor_out      = mult_factor(st_reg.mult_sel); // R12
    assign rx_pll_bw_out        = RX_PLL_BW; // R13
    assign eq_adapt_pd_out      = st_reg.eq_pd;
    assign preemph_out          = st_reg.preemph;
    assign tx_elec_idle_out     = st_reg.tx_idle;
    assign tx_oe_out            = !st_reg.tx_idle; // R04
    assign rxdet_pulse_out      = st_reg.det_pulse;
    assign irq_out              = |(st_reg.irq_stat & st_reg.irq_mask);

    // ==========================================================
    // Next state
    always_comb begin
        st_next = st_reg;
        irq_ev  = '0;
        // Write channel
        if (s_axi_awvalid_in && s_axi_awready_out) begin
            st_next.aw_got = 1'b1;
            st_next.awaddr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && s_axi_wready_out) begin
            st_next.w_got = 1'b1;
            st_next.wdata = s_axi_wdata_in;
            st_next.wstrb = s_axi_wstrb_in;
        end
        if (st_reg.bvalid && s_axi_bready_in) begin
            st_next.bvalid = 1'b0;
        end
        if (wr_fire) begin
            st_next.aw_got = 1'b0;
            st_next.w_got  = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp  = mapped(st_reg.awaddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (st_reg.awaddr[ADDR_W-1:2])
                OFS_CTRL[ADDR_W-1:2]: begin
                    st_next.ctrl = merge(st_reg.ctrl, st_reg.wdata, st_reg.wstrb)
                                   & CTRL_WR_MASK;
                end
                OFS_IRQ_MASK[ADDR_W-1:2]: begin
                    if (st_reg.wstrb[0]) begin
                        st_next.irq_mask = st_reg.wdata[IRQ_W-1:0];
                    end
                end
                OFS_PLL_CFG[ADDR_W-1:2]: begin
                    if (st_reg.wstrb[0]) begin
                        st_next.mult_sel = st_reg.wdata[2:0]; // R12
                    end
                end
                OFS_PREEMPH[ADDR_W-1:2]: begin
                    if (st_reg.wstrb[0]) begin
                        st_next.preemph = st_reg.wdata[PREEMPH_W-1:0]; // R15
                    end
                end
                default: begin
                end
            endcase
        end
        // Read channel
        if (st_reg.rvalid && s_axi_rready_in) begin
            st_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid_in && s_axi_arready_out) begin
            st_next.rvalid = 1'b1;
            st_next.rresp  = mapped(s_axi_araddr_in) ? RESP_OKAY : RESP_SLVERR;
            st_next.rdata  = '0;
            unique case (s_axi_araddr_in[ADDR_W-1:2])
                OFS_CTRL[ADDR_W-1:2]:     st_next.rdata = st_reg.ctrl;
                OFS_STATUS[ADDR_W-1:2]: begin
                    st_next.rdata[ST_PLL_LOCKED] = st_reg.pll_locked;
                    st_next.rdata[ST_FREQ_LOCK]  = st_reg.cru == CRU_DATA;
                    st_next.rdata[ST_PFD_LOCK]   = st_reg.pfd_lock;
                    st_next.rdata[ST_PD_LOCK]    = st_reg.pd_lock;
                    st_next.rdata[ST_RX_PRESENT] = st_reg.rx_present;
                    st_next.rdata[ST_DET_BUSY]   = st_reg.det != DET_IDLE;
                    st_next.rdata[ST_ELEC_IDLE]  = st_reg.tx_idle;
                end
                OFS_IRQ_STAT[ADDR_W-1:2]: st_next.rdata[IRQ_W-1:0] = st_reg.irq_stat;
                OFS_IRQ_MASK[ADDR_W-1:2]: st_next.rdata[IRQ_W-1:0] = st_reg.irq_mask;
                OFS_PLL_CFG[ADDR_W-1:2]:  st_next.rdata[2:0] = st_reg.mult_sel;
                OFS_PREEMPH[ADDR_W-1:2]:  st_next.rdata[PREEMPH_W-1:0] = st_reg.preemph;
                default: begin
                end
            endcase
        end
        // Electrical idle
        st_next.tx_idle = st_reg.ctrl[CTRL_PCIE] && force_elec_idle_in; // R04
        // Receiver detect
        st_next.det_pulse = 1'b0;
        unique case (st_reg.det)
            DET_IDLE: begin
                if (det_go) begin
                    st_next.det       = DET_PULSE; // R03
                    st_next.det_cnt   = 8'(DET_PULSE_CYC - 1);
                    st_next.det_pulse = 1'b1;
                end
            end
            DET_PULSE: begin
                st_next.det_pulse = st_reg.det_cnt != 8'h00;
                st_next.det_cnt   = st_reg.det_cnt - 8'h01;
                if (st_reg.det_cnt == 8'h00) begin
                    st_next.det     = DET_WAIT;
                    st_next.det_cnt = 8'(DET_WAIT_CYC - 1);
                end
            end
            DET_WAIT: begin
                st_next.det_cnt = st_reg.det_cnt - 8'h01;
                if (st_reg.det_cnt == 8'h00) begin
                    st_next.det        = DET_IDLE;
                    st_next.rx_present = reflection_in; // R03
                    irq_ev[IRQ_DET_DONE] = 1'b1;
                end
            end
        endcase
        if (!st_next.tx_idle) begin
            st_next.det       = DET_IDLE; // R03
            st_next.det_pulse = 1'b0;
        end
        // Clock recovery lock mode
        if (!chan_en) begin
            st_next.cru = CRU_REF; // R05
        end else if (force_data) begin
            st_next.cru = CRU_DATA; // R09
        end else if (force_ref) begin
            st_next.cru = CRU_REF; // R09
        end else if (st_reg.cru == CRU_REF) begin
            if (ppm_ok_in && ref_locked_in) begin
                st_next.cru = CRU_DATA; // R08
            end
        end else if (!ppm_ok_in) begin
            st_next.cru = CRU_REF; // R08
        end
        if (st_reg.cru == CRU_REF && st_next.cru == CRU_DATA) begin
            irq_ev[IRQ_DATA_LOCK] = 1'b1;
        end
        st_next.pll_locked = chan_en && ref_locked_in; // R06
        st_next.pfd_lock   = chan_en && st_next.cru == CRU_REF && ref_locked_in; // R11
        st_next.pd_lock    = chan_en && st_next.cru == CRU_DATA && data_locked_in; // R11
        if (st_reg.pll_locked && !st_next.pll_locked) begin
            irq_ev[IRQ_PLL_LOST] = 1'b1;
        end
        // Equalizer power down only after settling
        st_next.eq_pd = st_reg.ctrl[CTRL_EQ_PD] && (st_reg.eq_pd || eq_settled_in); // R14
        // Sticky status, set wins over clear
        st_next.irq_stat = (st_reg.irq_stat & ~irq_clr) | irq_ev;
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            st_reg          <= '0;
            st_reg.bresp    <= RESP_OKAY;
            st_reg.rresp    <= RESP_OKAY;
            st_reg.ctrl     <= CTRL_RESET;
            st_reg.mult_sel <= MULT_SEL_RESET;
            st_reg.preemph  <= PREEMPH_INIT[PREEMPH_W-1:0];
            st_reg.cru      <= CRU_REF;
            st_reg.det      <= DET_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // Serializer
    tx_serializer #(
        .MAX_W          (MAX_W)
    ) u_ser (
        .clk_in         (clk_in),
        .reset_in       (reset_in),
        .enable_in      (!st_reg.tx_idle),
        .width_sel_in   (st_reg.ctrl[CTRL_WIDTH_LSB +: 2]),
        .word_in        (tx_word_in),
        .word_valid_in  (tx_word_valid_in),
        .word_ready_out (tx_word_ready_out),
        .serial_out     (tx_serial_out)
    );

    // ==========================================================
    // Checks
    sequence s_det_start;
        det_go;
    endsequence

    sequence s_idle_held;
        st_reg.tx_idle [*5];
    endsequence

    a_det_pulse_len: assert property (@(posedge clk_in) disable iff (reset_in) // R03
        s_det_start ##1 s_idle_held |-> !rxdet_pulse_out && $past(rxdet_pulse_out, 4)
            && $past(rxdet_pulse_out))
        else $error("detect pulse length wrong");

    a_det_idle_only: assert property (@(posedge clk_in) disable iff (reset_in) // R03
        st_reg.det != DET_IDLE |-> tx_elec_idle_out && !tx_oe_out)
        else $error("detect ran outside electrical idle");

    a_idle_forced: assert property (@(posedge clk_in) disable iff (reset_in) // R04
        st_reg.ctrl[CTRL_PCIE] && force_elec_idle_in |=> tx_elec_idle_out && !tx_oe_out)
        else $error("forced idle not applied");

    a_unused_pd: assert property (@(posedge clk_in) disable iff (reset_in) // R05
        !chan_en |=> !freq_locked_out && !rx_pll_locked_out && !pd_lock_out)
        else $error("unused channel reports lock");

    a_force_data: assert property (@(posedge clk_in) disable iff (reset_in) // R09
        chan_en && force_data |=> freq_locked_out)
        else $error("data lock override ignored");

    a_force_ref: assert property (@(posedge clk_in) disable iff (reset_in) // R09
        chan_en && !force_data && force_ref |=> !freq_locked_out)
        else $error("reference lock override ignored");

    a_auto_ppm: assert property (@(posedge clk_in) disable iff (reset_in) // R08
        !freq_locked_out && !force_data && !ppm_ok_in |=> !freq_locked_out)
        else $error("data lock taken outside ppm window");

    a_irq_set_wins: assert property (@(posedge clk_in) disable iff (reset_in)
        irq_ev[IRQ_DET_DONE] |=> st_reg.irq_stat[IRQ_DET_DONE] && st_reg.rx_present
            == $past(reflection_in))
        else $error("detect done lost");

endmodule // serdes_ctrl

//--- src/serdes_ctrl_pkg.sv
// Operation
// R01 - Serializer takes 8, 10, 16 or 20 bit words and sends LSB first.
// R02 - A new word loads every N bit times, N being the word width.
// R03 - PCIe receiver detect pulses the lane only while transmitter sits idle.
// R04 - Force-idle input puts transmitter into electrical idle, PCIe mode only.
// R05 - Unused receive channel keeps its receiver PLL and recovery unit powered down. Code powers down only the PLL; recovery unit held in reference lock.
// R06 - Receiver PLL lock output is high while PLL locks to reference.
// R07 - Frequency-lock output is high while recovery unit locks to data.
// R08 - Automatic mode moves to data lock only within the ppm threshold.
// R09 - Data-lock override wins; reference override alone forces reference; none means automatic.
// R10 - Unconnected override inputs leave the recovery unit in automatic mode.
// R11 - Separate lock indications for reference lock and data lock.
// R12 - PLL multiplication factor selectable among 1, 4, 5, 8, 10, 16, 20, 25.
// R13 - PLL loop bandwidth is static: low, medium or high.
// R14 - Adaptive equalizer may be powered down once it has settled.
// R15 - Pre-emphasis fixed at start or changed at run time over the bus.
package serdes_ctrl_pkg;

    // ==========================================================
    // Register map
    localparam int          ADDR_W       = 8;
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_STATUS   = 8'h04;
    localparam logic [7:0]  OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0]  OFS_IRQ_MASK = 8'h0c;
    localparam logic [7:0]  OFS_PLL_CFG  = 8'h10;
    localparam logic [7:0]  OFS_PREEMPH  = 8'h14;

    // ==========================================================
    // Control fields
    localparam int          CTRL_CHAN_EN    = 0;
    localparam int          CTRL_PCIE       = 1;
    localparam int          CTRL_DET_START  = 2;
    localparam int          CTRL_FORCE_REF  = 3;
    localparam int          CTRL_FORCE_DATA = 4;
    localparam int          CTRL_EQ_PD      = 5;
    localparam int          CTRL_WIDTH_LSB  = 8;
    localparam logic [31:0] CTRL_WR_MASK    = 32'h0000_033b;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0100;

    // Status fields
    localparam int ST_PLL_LOCKED = 0;
    localparam int ST_FREQ_LOCK  = 1;
    localparam int ST_PFD_LOCK   = 2;
    localparam int ST_PD_LOCK    = 3;
    localparam int ST_RX_PRESENT = 4;
    localparam int ST_DET_BUSY   = 5;
    localparam int ST_ELEC_IDLE  = 6;

    // Interrupt fields
    localparam int IRQ_W         = 3;
    localparam int IRQ_DET_DONE  = 0;
    localparam int IRQ_DATA_LOCK = 1;
    localparam int IRQ_PLL_LOST  = 2;

    localparam logic [2:0] MULT_SEL_RESET = 3'h0;
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;
    localparam logic [1:0] BW_LOW         = 2'h0;
    localparam logic [1:0] BW_MEDIUM      = 2'h1;
    localparam logic [1:0] BW_HIGH        = 2'h2;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_PS = 25000;
    localparam int DET_PULSE_NS  = 100;
    localparam int DET_WAIT_NS   = 1000;
    localparam int DET_PULSE_CYC = (DET_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DET_WAIT_CYC  = (DET_WAIT_NS * 1000) / CLK_PERIOD_PS;

    // ==========================================================
    // States
    typedef enum logic [1:0] {
        CRU_REF  = 2'b01,
        CRU_DATA = 2'b10
    } cru_type;

    typedef enum logic [2:0] {
        DET_IDLE  = 3'b001,
        DET_PULSE = 3'b010,
        DET_WAIT  = 3'b100
    } det_type;

    // ==========================================================
    // Lookups
    function automatic logic [4:0] width_bits(input logic [1:0] sel);
        case (sel)
            2'h0:    width_bits = 5'h08;
            2'h1:    width_bits = 5'h0a;
            2'h2:    width_bits = 5'h10;
            default: width_bits = 5'h14;
        endcase
    endfunction

    function automatic logic [4:0] mult_factor(input logic [2:0] sel);
        case (sel)
            3'h0:    mult_factor = 5'h01;
            3'h1:    mult_factor = 5'h04;
            3'h2:    mult_factor = 5'h05;
            3'h3:    mult_factor = 5'h08;
            3'h4:    mult_factor = 5'h0a;
            3'h5:    mult_factor = 5'h10;
            3'h6:    mult_factor = 5'h14;
            default: mult_factor = 5'h19;
        endcase
    endfunction

endpackage

//--- src/tx_serializer.sv
`timescale 1ns/100ps
module tx_serializer
    import serdes_ctrl_pkg::*;
#(
    parameter int MAX_W = 20
) (
    input  wire logic             clk_in,
    input  wire logic             reset_in,
    input  wire logic             enable_in,
    input  wire logic [1:0]       width_sel_in,
    input  wire logic [MAX_W-1:0] word_in,
    input  wire logic             word_valid_in,
    output logic                  word_ready_out,
    output logic                  serial_out
);

    typedef struct packed {
        logic [MAX_W-1:0] shift;
        logic [4:0]       cnt;
    } ser_state_type;

    ser_state_type st_reg;
    ser_state_type st_next;

    // ==========================================================
    // Word load and shift
    assign word_ready_out = enable_in && (st_reg.cnt <= 5'h01); // R02
    assign serial_out     = st_reg.shift[0];

    always_comb begin
        st_next = st_reg;
        if (word_ready_out) begin
            st_next.shift = word_valid_in ? word_in : '0; // R01
            st_next.cnt   = width_bits(width_sel_in); // R02
        end else if (enable_in && st_reg.cnt != 5'h00) begin
            st_next.shift = st_reg.shift >> 1; // R01
            st_next.cnt   = st_reg.cnt - 5'h01;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // Checks
    a_lsb_first: assert property (@(posedge clk_in) disable iff (reset_in) // R01
        word_ready_out && word_valid_in |=> serial_out == $past(word_in[0]))
        else $error("serializer did not start with bit zero");

    a_word_spacing: assert property (@(posedge clk_in) disable iff (reset_in) // R02
        word_ready_out |=> !word_ready_out [*7])
        else $error("serializer loaded a word early");

endmodule // tx_serializer

//--- test/far_end.sv
`timescale 1ns/100ps
module far_end (
    input  wire logic clk_in,
    input  wire logic reset_in,
    input  wire logic present_in,
    input  wire logic pulse_in,
    input  wire logic oe_in,
    output logic      reflection_out
);
    logic seen_reg;
    // ==========
    // Echo of a pulse sent on an idle lane
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            seen_reg <= 1'b0;
        end else if (pulse_in) begin
            seen_reg <= present_in && !oe_in;
        end
    end
    assign reflection_out = seen_reg;
endmodule // far_end

//--- test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import serdes_ctrl_pkg::*;
    logic clk_in = 0, reset_in = 1, present = 1;
    logic [7:0] s_axi_awaddr_in = 0, s_axi_araddr_in = 0;
    logic [31:0] s_axi_wdata_in = 0, s_axi_rdata_out, w;
    logic [3:0] s_axi_wstrb_in = 4'hf, t;
    logic s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0;
    logic s_axi_arvalid_in = 0, s_axi_rready_in = 0, tx_word_valid_in = 1;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
    logic s_axi_rvalid_out, tx_word_ready_out, tx_serial_out, tx_oe_out, tx_elec_idle_out;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rx_pll_bw_out;
    logic [19:0] tx_word_in = 0;
    logic force_elec_idle_in = 0, lock_to_data_in = 0, lock_to_ref_in = 0, ppm_ok_in = 0;
    logic ref_locked_in = 1, data_locked_in = 1, eq_settled_in = 0, reflection_in;
    logic rxdet_pulse_out, lock_to_data_sel_out, rx_pll_locked_out, freq_locked_out;
    logic pfd_lock_out, pd_lock_out, rx_pll_pd_out, eq_adapt_pd_out, irq_out;
    logic [4:0] mult_factor_out, preemph_out;
    int err_count = 0, compares = 0, n, c;
    serdes_ctrl dut (.*);
    far_end u_far (.clk_in(clk_in), .reset_in(reset_in), .present_in(present),
        .pulse_in(rxdet_pulse_out), .oe_in(tx_oe_out), .reflection_out(reflection_in));
    always #12.5 clk_in = ~clk_in;
    function automatic logic [4:0] fac(input int i);
        logic [4:0] f[8] = '{1, 4, 5, 8, 10, 16, 20, 25};
        return f[i];
    endfunction
    task automatic chk(input logic [39:0] g, input logic [39:0] e);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic summarize;
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic lim;
        if (n >= 60) begin
            err_count++;
            summarize();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        n = 0;
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= 1;
        s_axi_wvalid_in <= 1;
        s_axi_bready_in <= 1;
        while (s_axi_bvalid_out !== 1'b1 && n < 60) begin
            @(posedge clk_in);
            n++;
            if (s_axi_awready_out) s_axi_awvalid_in <= 0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 0;
        end
        lim();
        chk(s_axi_bresp_out, r);
        s_axi_bready_in <= 0;
        @(posedge clk_in);
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        n = 0;
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1;
        s_axi_rready_in <= 1;
        while (s_axi_rvalid_out !== 1'b1 && n < 60) begin
            @(posedge clk_in);
            n++;
            if (s_axi_arready_out) s_axi_arvalid_in <= 0;
        end
        lim();
        chk({s_axi_rresp_out, s_axi_rdata_out}, e);
        s_axi_rready_in <= 0;
        @(posedge clk_in);
    endtask
    initial begin
        void'($urandom(17872));
        repeat (2) @(posedge clk_in);
        reset_in <= 0;
        @(posedge clk_in);
        chk({rx_pll_pd_out, mult_factor_out, irq_out}, 7'h42);
        rd(OFS_CTRL, CTRL_RESET);
        rd(8'h20, {RESP_SLVERR, 32'h0});
        for (int i = 0; i < 8; i++) begin
            wr(OFS_PLL_CFG, i, RESP_OKAY);
            chk(mult_factor_out, fac(i));
        end
        w = $urandom & 32'h1f;
        wr(OFS_PREEMPH, w, RESP_OKAY);
        chk({preemph_out, rx_pll_bw_out}, {w[4:0], BW_MEDIUM});
        for (int s = 0; s < 4; s++) begin
            wr(OFS_CTRL, 32'h21 | (s << 8), RESP_OKAY);
            chk({rx_pll_pd_out, eq_adapt_pd_out}, {1'b0, s > 0});
            eq_settled_in <= 1;
            for (int k = 0; k < 4; k++) begin
                for (n = 0; tx_word_ready_out !== 1'b1 && n < 60; n++) @(posedge clk_in);
                if (k > 0) chk(n, 0);
                lim();
                w = tx_word_in;
                tx_word_in <= 20'($urandom);
                for (int b = 0; b < width_bits(2'(s)); b++) begin
                    @(posedge clk_in);
                    chk(tx_serial_out, w[b]);
                end
            end
        end
        force_elec_idle_in <= 1;
        repeat (3) @(posedge clk_in);
        chk({tx_elec_idle_out, tx_oe_out}, 2'b01);
        wr(OFS_CTRL, 32'h03, RESP_OKAY);
        chk({tx_elec_idle_out, tx_oe_out}, 2'b10);
        for (int p = 1; p >= 0; p--) begin
            present <= 1'(p);
            wr(OFS_IRQ_MASK, p, RESP_OKAY);
            c = 0;
            fork
                wr(OFS_CTRL, 32'h07, RESP_OKAY);
                repeat (60) @(posedge clk_in) c += rxdet_pulse_out;
            join
            chk(c, DET_PULSE_CYC);
            chk(irq_out, p);
            rd(OFS_STATUS, 32'h45 | (p << 4));
            wr(OFS_IRQ_STAT, 32'h1, RESP_OKAY);
            chk(irq_out, 0);
        end
        force_elec_idle_in <= 0;
        wr(OFS_CTRL, 32'h01, RESP_OKAY);
        for (int i = 0; i < 6; i++) begin
            t = 4'(24'h09d630 >> (i * 4));
            {lock_to_data_in, lock_to_ref_in, ppm_ok_in} <= t[3:1];
            repeat (3) @(posedge clk_in);
            chk({lock_to_data_sel_out, freq_locked_out}, {2{t[0]}});
            chk({rx_pll_locked_out, pfd_lock_out, pd_lock_out}, {1'b1, !t[0], t[0]});
        end
        summarize();
    end
endmodule // tb_top
